// ---- src/audio_tone_volume_mute_ctrl.sv ----
// Purpose: per-channel tone selection, soft volume, soft mute and automute
// Assumes: one sample per handshake, tagged with its channel index 0..7
// Notes: gains are 7.18 unsigned linear; biquad and loudness math lie downstream
// Overview of operation
// - Below the high-rate mode four independent tone units serve channel groups
// - Unit 0 serves channels 1,2,7; unit 1 3,4; unit 2 5,6; unit 3 channel 8
// - High-rate mode keeps two tone units: left/right pair and subwoofer
// - Tone levels move gradually toward their targets at a programmable slew
// - Bass set, bass index, treble set, treble index and slew are writable; five sets
// - Tone bypass per channel resets to bypass; tone acts only when inline
// - Channel and master volume run +18 dB to -109 dB in quarter-dB steps
// - Channel plus master gives +36 dB to -218 dB, with mute beyond
// - Master mute from pin or register; channel mutes from registers only
// - Soft ramps move linear gain by a selectable power-of-two step per interval
// - Two enable bits switch input and output automute; both on after reset
// - Input detector mutes all when all eight inputs stay quiet a full period
// - Output detector mutes one channel when it stays quiet a full period
// - Period is 1-5, 10, 20..110 ms, timed from the core clock
// - Entry threshold is a bit position 0..12, shared with the period by both
// - One sample above the exit threshold ends automute; exit is entry or entry+1
// - The sample that ends automute passes with full gain
// - Any mute source beats unmute and volume changes
// - Unmute ramps to the latest volume written, even while muted
// - One loudness setting for all channels follows the largest channel volume
// - High-rate mode applies loudness to channels 1, 2 and 8 only
// - Six-channel master mode still gives loudness to all eight outputs
`timescale 1ns/1ps
module audio_tone_volume_mute_ctrl #(
  parameter int MS_CYCLES = tone_vol_pkg::MS_CYC,
  parameter int RAMP_CYCLES = tone_vol_pkg::RAMP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic master_mute_pin_i,
  input wire logic seq_mute_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [2:0] in_chan_i,
  input wire logic [23:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [2:0] out_chan_o,
  output logic [23:0] out_data_o,
  output logic [1:0] out_tone_unit_o,
  output logic out_tone_en_o,
  output logic out_loud_en_o,
  output logic [11:0] low_set_o,
  output logic [11:0] high_set_o,
  output logic [31:0] low_level_o,
  output logic [31:0] high_level_o,
  output logic [8:0] loud_vol_o
);
  function automatic logic [17:0] mant(input logic [4:0] k);
    case (k)
      5'd0: mant = 18'h20000;
      5'd1: mant = 18'h1f16d;
      5'd2: mant = 18'h1e344;
      5'd3: mant = 18'h1d582;
      5'd4: mant = 18'h1c824;
      5'd5: mant = 18'h1bb28;
      5'd6: mant = 18'h1ae8a;
      5'd7: mant = 18'h1a249;
      5'd8: mant = 18'h19660;
      5'd9: mant = 18'h18acf;
      5'd10: mant = 18'h17f91;
      5'd11: mant = 18'h174a6;
      5'd12: mant = 18'h16a0a;
      5'd13: mant = 18'h15fbc;
      5'd14: mant = 18'h155b8;
      5'd15: mant = 18'h14bfe;
      5'd16: mant = 18'h1428a;
      5'd17: mant = 18'h1395c;
      5'd18: mant = 18'h13070;
      5'd19: mant = 18'h127c6;
      5'd20: mant = 18'h11f5a;
      5'd21: mant = 18'h1172c;
      5'd22: mant = 18'h10f39;
      default: mant = 18'h10781;
    endcase
  endfunction

  // Code 0 is +36 dB; 24 quarter-dB codes per halving of gain
  function automatic logic [24:0] lin_gain(input logic [9:0] code);
    logic [9:0] sh;
    sh = code / 10'd24;
    lin_gain = {mant(5'(code % 10'd24)), 7'h00} >> sh;
  endfunction

  function automatic logic [6:0] period_ms(input logic [3:0] sel);
    if (sel < 4'd5) begin
      period_ms = 7'(sel) + 7'd1;
    end else if (sel == 4'd5) begin
      period_ms = 7'd10;
    end else begin
      period_ms = 7'(sel - 4'd4) * 7'd10;
    end
  endfunction

  function automatic logic [1:0] tone_unit(input logic [2:0] ch);
    case (ch)
      3'd0, 3'd1, 3'd6: tone_unit = 2'd0;
      3'd2, 3'd3: tone_unit = 2'd1;
      3'd4, 3'd5: tone_unit = 2'd2;
      default: tone_unit = 2'd3;
    endcase
  endfunction

  function automatic logic hi_rate_ch(input logic [2:0] ch);
    hi_rate_ch = (ch == 3'd0) || (ch == 3'd1) || (ch == 3'd7);
  endfunction

  function automatic logic [2:0] clamp_set(input logic [2:0] s);
    clamp_set = (s > tone_vol_pkg::SET_MAX) ? tone_vol_pkg::SET_MAX : s;
  endfunction

  logic [7:0] am_ctl;
  logic [3:0] am_thr;
  logic am_exit_up;
  logic [3:0] am_period;
  logic [7:0] bypass;
  logic [7:0] slew;
  logic [2:0] low_set [4];
  logic [2:0] high_set [4];
  logic [7:0] low_idx [4];
  logic [7:0] high_idx [4];
  logic [7:0] low_lvl [4];
  logic [7:0] high_lvl [4];
  logic [8:0] ch_vol [8];
  logic [8:0] mst_vol;
  logic [7:0] ch_mute;
  logic mst_mute;
  logic [2:0] step_sel;
  logic six_mode;
  logic hi_rate;
  logic [24:0] cur [8];
  logic [24:0] tgt [8];
  logic [24:0] tgt_free [8];
  logic [6:0] am_cnt [8];
  logic [6:0] all_cnt;
  logic [7:0] quiet;
  logic [7:0] am_out_mute;
  logic [7:0] mute_free;
  logic [7:0] exit_now;
  logic in_am;
  logic [17:0] ms_cnt;
  logic [17:0] ramp_cnt;
  logic ms_tick;
  logic ramp_tick;
  logic [7:0] slew_cnt;
  logic tone_tick;
  logic [30:0] head;
  logic [30:0] spare;
  logic spare_v;
  logic take;
  logic pop;
  logic [23:0] mag;
  logic loud_entry;
  logic loud_exit;
  logic [24:0] stp;
  logic [6:0] per;
  logic [49:0] prod;
  logic [31:0] scaled;
  logic [23:0] sat;
  logic [30:0] entry;
  logic [8:0] next_loud;

  assign take = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign mag = in_data_i[23] ? 24'(-in_data_i) : in_data_i;
  assign loud_entry = |(mag >> am_thr);
  assign loud_exit = |(mag >> (am_thr + {3'h0, am_exit_up}));
  assign stp = tone_vol_pkg::STEP_MAX >> step_sel;
  assign per = period_ms(am_period);
  assign in_am = am_ctl[tone_vol_pkg::AM_IN_BIT] && (all_cnt >= per);
  assign ms_tick = (ms_cnt == 18'(MS_CYCLES - 1));
  assign ramp_tick = (ramp_cnt == 18'(RAMP_CYCLES - 1));
  assign tone_tick = ramp_tick && (slew_cnt >= slew);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      am_ctl <= tone_vol_pkg::AM_EN_RST;
      am_thr <= tone_vol_pkg::AM_THR_RST;
      am_exit_up <= 1'b0;
      am_period <= tone_vol_pkg::AM_PER_RST;
      bypass <= 8'hff;
      slew <= tone_vol_pkg::SLEW_RST;
      mst_vol <= tone_vol_pkg::VOL_RST;
      ch_mute <= 8'h00;
      mst_mute <= 1'b0;
      step_sel <= tone_vol_pkg::STEP_RST;
      six_mode <= 1'b0;
      hi_rate <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        ch_vol[i] <= tone_vol_pkg::VOL_RST;
      end
      for (int u = 0; u < 4; u++) begin
        low_set[u] <= 3'h0;
        high_set[u] <= 3'h0;
        low_idx[u] <= tone_vol_pkg::TONE_IDX_RST;
        high_idx[u] <= tone_vol_pkg::TONE_IDX_RST;
      end
    end else if (reg_wr_i) begin
      // Volume writes land even while muted and take effect on unmute
      case (reg_addr_i)
        tone_vol_pkg::A_AM_EN: am_ctl <= reg_wdata_i[7:0];
        tone_vol_pkg::A_AM_IN: begin
          am_thr <= (reg_wdata_i[3:0] > 4'd12) ? 4'd12 : reg_wdata_i[3:0];
          am_exit_up <= reg_wdata_i[tone_vol_pkg::EXIT_UP_BIT];
        end
        tone_vol_pkg::A_AM_OUT: am_period <= reg_wdata_i[3:0];
        tone_vol_pkg::A_SLEW: slew <= reg_wdata_i[7:0];
        tone_vol_pkg::A_MST_VOL: mst_vol <= reg_wdata_i[8:0];
        tone_vol_pkg::A_MUTE: begin
          ch_mute <= reg_wdata_i[7:0];
          mst_mute <= reg_wdata_i[tone_vol_pkg::MST_MUTE_BIT];
        end
        tone_vol_pkg::A_VOL_CFG: begin
          step_sel <= reg_wdata_i[2:0];
          six_mode <= reg_wdata_i[tone_vol_pkg::SIX_BIT];
          hi_rate <= reg_wdata_i[tone_vol_pkg::HI_RATE_BIT];
        end
        default: begin
          for (int i = 0; i < 8; i++) begin
            if (reg_addr_i == tone_vol_pkg::A_BYPASS + 8'(i)) bypass[i] <= reg_wdata_i[0];
            if (reg_addr_i == tone_vol_pkg::A_CH_VOL + 8'(i)) ch_vol[i] <= reg_wdata_i[8:0];
          end
          for (int u = 0; u < 4; u++) begin
            if (reg_addr_i == tone_vol_pkg::A_LOW_SET) begin
              low_set[u] <= clamp_set(reg_wdata_i[8*u+:3]);
            end
            if (reg_addr_i == tone_vol_pkg::A_HIGH_SET) begin
              high_set[u] <= clamp_set(reg_wdata_i[8*u+:3]);
            end
            if (reg_addr_i == tone_vol_pkg::A_LOW_IDX) low_idx[u] <= reg_wdata_i[8*u+:8];
            if (reg_addr_i == tone_vol_pkg::A_HIGH_IDX) high_idx[u] <= reg_wdata_i[8*u+:8];
          end
        end
      endcase
    end
  end

  // Automute period is timed from the core clock, not the sample rate
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt <= 18'h00000;
      ramp_cnt <= 18'h00000;
      slew_cnt <= 8'h00;
    end else begin
      ms_cnt <= ms_tick ? 18'h00000 : ms_cnt + 18'h00001;
      ramp_cnt <= ramp_tick ? 18'h00000 : ramp_cnt + 18'h00001;
      if (tone_tick) begin
        slew_cnt <= 8'h00;
      end else if (ramp_tick) begin
        slew_cnt <= slew_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      all_cnt <= 7'h00;
    end else if (take && (in_am ? loud_exit : loud_entry)) begin
      all_cnt <= 7'h00;
    end else if (ms_tick && (&quiet) && all_cnt != 7'h7f) begin
      all_cnt <= all_cnt + 7'h01;
    end
  end

  genvar c;
  generate
    for (c = 0; c < 8; c++) begin : g_ch
      logic hit;
      logic [9:0] code;
      assign hit = take && (in_chan_i == 3'(c));
      assign am_out_mute[c] = am_ctl[tone_vol_pkg::AM_OUT_BIT] && (am_cnt[c] >= per);
      assign mute_free[c] = mst_mute | master_mute_pin_i | ch_mute[c] | seq_mute_i;
      assign code = {1'b0, ch_vol[c]} + ((six_mode && (c == 4 || c == 5)) ?
                    {1'b0, tone_vol_pkg::VOL_UNITY} : {1'b0, mst_vol});
      assign tgt_free[c] = (mute_free[c] || ch_vol[c] >= tone_vol_pkg::VOL_MUTE ||
                            mst_vol >= tone_vol_pkg::VOL_MUTE) ? 25'h0 : lin_gain(code);
      assign tgt[c] = (am_out_mute[c] || in_am) ? 25'h0 : tgt_free[c];
      assign exit_now[c] = hit && (am_out_mute[c] || in_am) && loud_exit;

      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          am_cnt[c] <= 7'h00;
          quiet[c] <= 1'b0;
        end else begin
          if (hit) quiet[c] <= !loud_entry;
          if (hit && (am_out_mute[c] ? loud_exit : loud_entry)) begin
            am_cnt[c] <= 7'h00;
          end else if (ms_tick && quiet[c] && am_cnt[c] != 7'h7f) begin
            am_cnt[c] <= am_cnt[c] + 7'h01;
          end
        end
      end

      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cur[c] <= 25'h0;
        end else if (exit_now[c]) begin
          cur[c] <= tgt_free[c];
        end else if (ramp_tick && cur[c] < tgt[c]) begin
          cur[c] <= (tgt[c] - cur[c] > stp) ? cur[c] + stp : tgt[c];
        end else if (ramp_tick && cur[c] > tgt[c]) begin
          cur[c] <= (cur[c] - tgt[c] > stp) ? cur[c] - stp : tgt[c];
        end
      end
    end

    for (c = 0; c < 4; c++) begin : g_unit
      assign low_set_o[3*c+:3] = low_set[c];
      assign high_set_o[3*c+:3] = high_set[c];
      assign low_level_o[8*c+:8] = low_lvl[c];
      assign high_level_o[8*c+:8] = high_lvl[c];
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          low_lvl[c] <= tone_vol_pkg::TONE_IDX_RST;
          high_lvl[c] <= tone_vol_pkg::TONE_IDX_RST;
        end else if (tone_tick) begin
          // One index step per slew period keeps coefficient swaps inaudible
          if (low_lvl[c] != low_idx[c]) begin
            low_lvl[c] <= (low_lvl[c] < low_idx[c]) ? low_lvl[c] + 8'h01 : low_lvl[c] - 8'h01;
          end
          if (high_lvl[c] != high_idx[c]) begin
            high_lvl[c] <= (high_lvl[c] < high_idx[c]) ? high_lvl[c] + 8'h01 : high_lvl[c] - 8'h01;
          end
        end
      end
    end
  endgenerate

  // The exiting sample uses the unmuted gain so it is not lost in the ramp
  assign prod = $signed(in_data_i) * $signed({1'b0, exit_now[in_chan_i] ?
                tgt_free[in_chan_i] : cur[in_chan_i]});
  assign scaled = prod[49:18];
  assign sat = ($signed(scaled) > $signed(32'h007fffff)) ? 24'h7fffff :
               ($signed(scaled) < $signed(32'hff800000)) ? 24'h800000 : scaled[23:0];
  assign entry = {!hi_rate || hi_rate_ch(in_chan_i),
                  !bypass[in_chan_i] && (!hi_rate || hi_rate_ch(in_chan_i)),
                  hi_rate ? ((in_chan_i == 3'd7) ? 2'd3 : 2'd0) : tone_unit(in_chan_i),
                  in_chan_i, sat};

  assign out_loud_en_o = head[30];
  assign out_tone_en_o = head[29];
  assign out_tone_unit_o = head[28:27];
  assign out_chan_o = head[26:24];
  assign out_data_o = head[23:0];

  // Two-entry buffer: ready is registered, so the spare slot absorbs the in-flight word
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head <= 31'h0;
      spare <= 31'h0;
      out_valid_o <= 1'b0;
      spare_v <= 1'b0;
      in_ready_o <= 1'b0;
    end else begin
      if (pop) begin
        out_valid_o <= spare_v || take;
        head <= spare_v ? spare : entry;
        spare <= entry;
        spare_v <= spare_v && take;
        in_ready_o <= !(spare_v && take);
      end else if (take) begin
        if (out_valid_o) begin
          spare <= entry;
          spare_v <= 1'b1;
        end else begin
          head <= entry;
        end
        out_valid_o <= 1'b1;
        in_ready_o <= !out_valid_o;
      end else begin
        in_ready_o <= !(out_valid_o && spare_v);
      end
    end
  end

  always_comb begin
    next_loud = ch_vol[0];
    for (int i = 1; i < 8; i++) begin
      if (ch_vol[i] < next_loud) next_loud = ch_vol[i];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loud_vol_o <= tone_vol_pkg::VOL_RST;
      reg_rdata_o <= 32'h0;
    end else begin
      loud_vol_o <= next_loud;
      reg_rdata_o <= 32'h0;
      case (reg_addr_i)
        tone_vol_pkg::A_STATUS: reg_rdata_o <= {23'h0, in_am, am_out_mute};
        tone_vol_pkg::A_MUTE: reg_rdata_o <= {23'h0, mst_mute, ch_mute};
        tone_vol_pkg::A_AM_EN: reg_rdata_o <= {24'h0, am_ctl};
        tone_vol_pkg::A_VOL_CFG: reg_rdata_o <= {27'h0, hi_rate, six_mode, step_sel};
        tone_vol_pkg::A_AM_IN: reg_rdata_o <= {27'h0, am_exit_up, am_thr};
        tone_vol_pkg::A_AM_OUT: reg_rdata_o <= {28'h0, am_period};
        tone_vol_pkg::A_SLEW: reg_rdata_o <= {24'h0, slew};
        tone_vol_pkg::A_MST_VOL: reg_rdata_o <= {23'h0, mst_vol};
        tone_vol_pkg::A_LOW_SET: reg_rdata_o <= {5'h0, low_set[3], 5'h0, low_set[2],
                                                 5'h0, low_set[1], 5'h0, low_set[0]};
        tone_vol_pkg::A_HIGH_SET: reg_rdata_o <= {5'h0, high_set[3], 5'h0, high_set[2],
                                                  5'h0, high_set[1], 5'h0, high_set[0]};
        tone_vol_pkg::A_LOW_IDX: reg_rdata_o <= {low_idx[3], low_idx[2], low_idx[1], low_idx[0]};
        tone_vol_pkg::A_HIGH_IDX: reg_rdata_o <= {high_idx[3], high_idx[2], high_idx[1],
                                                  high_idx[0]};
        default: begin
          for (int i = 0; i < 8; i++) begin
            if (reg_addr_i == tone_vol_pkg::A_BYPASS + 8'(i)) reg_rdata_o <= {31'h0, bypass[i]};
            if (reg_addr_i == tone_vol_pkg::A_CH_VOL + 8'(i)) reg_rdata_o <= {23'h0, ch_vol[i]};
          end
        end
      endcase
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_bypass;
    take && bypass[in_chan_i] && !out_valid_o |=> out_valid_o && !out_tone_en_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypassed channel got tone");
  property p_no_over;
    (cur[0] <= tgt[0]) ##1 ($stable(tgt[0]) && !$past(exit_now[0])) |-> cur[0] <= tgt[0];
  endproperty
  a_no_over: assert property (p_no_over) else $error("gain ramp overshot target");
  property p_mute_down;
    mute_free[0] && ramp_tick && !exit_now[0] |=> cur[0] <= $past(cur[0]);
  endproperty
  a_mute_down: assert property (p_mute_down) else $error("gain rose under mute");
  property p_step;
    ramp_tick && !exit_now[0] |=> ((cur[0] >= $past(cur[0])) ? cur[0] - $past(cur[0]) :
                                  $past(cur[0]) - cur[0]) <= $past(stp);
  endproperty
  a_step: assert property (p_step) else $error("ramp step too large");
  property p_exit;
    exit_now[0] |=> cur[0] == $past(tgt_free[0]);
  endproperty
  a_exit: assert property (p_exit) else $error("exit did not restore gain");
  property p_am_off;
    !am_ctl[tone_vol_pkg::AM_OUT_BIT] |-> am_out_mute == 8'h00;
  endproperty
  a_am_off: assert property (p_am_off) else $error("automute while disabled");
  property p_loud;
    1 |=> loud_vol_o <= $past(ch_vol[0]) && loud_vol_o <= $past(ch_vol[7]);
  endproperty
  a_loud: assert property (p_loud) else $error("loudness volume not the largest");
  property p_hi_loud;
    take && hi_rate && (in_chan_i inside {[3'd2:3'd6]}) |-> !entry[30] && !entry[29];
  endproperty
  a_hi_loud: assert property (p_hi_loud) else $error("loudness on wrong channel");
  property p_full;
    out_valid_o && spare_v |-> !in_ready_o;
  endproperty
  a_full: assert property (p_full) else $error("ready while buffer full");
  c_exit: cover property (exit_now[0]);
  c_reach: cover property (ramp_tick && cur[0] != tgt[0] ##1 cur[0] == tgt[0]);
  c_full: cover property (out_valid_o && spare_v && !out_ready_i);
endmodule

// ---- src/tone_vol_pkg.sv ----
// Purpose: constants for the tone, volume and mute controller
// Assumes: 250 MHz core clock, 8-bit register subaddress, 32-bit register words
// Notes: mask-programmable defaults are plain values here
package tone_vol_pkg;
  localparam int CLK_MHZ = 250;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS * CLK_MHZ / 1000;
  // Ramp interval: full 36 dB swing at step 0.5 takes 128 steps in 10.67 ms
  localparam int RAMP_NS = 83333;
  localparam int RAMP_CYC = RAMP_NS * CLK_MHZ / 1000;
  localparam logic [7:0] A_STATUS = 8'h02;
  localparam logic [7:0] A_MUTE = 8'h03;
  localparam logic [7:0] A_AM_EN = 8'h04;
  localparam logic [7:0] A_VOL_CFG = 8'h0e;
  localparam logic [7:0] A_AM_IN = 8'h14;
  localparam logic [7:0] A_AM_OUT = 8'h15;
  localparam logic [7:0] A_BYPASS = 8'h89;
  localparam logic [7:0] A_SLEW = 8'hd0;
  localparam logic [7:0] A_CH_VOL = 8'hd1;
  localparam logic [7:0] A_MST_VOL = 8'hd9;
  localparam logic [7:0] A_LOW_SET = 8'hda;
  localparam logic [7:0] A_LOW_IDX = 8'hdb;
  localparam logic [7:0] A_HIGH_SET = 8'hdc;
  localparam logic [7:0] A_HIGH_IDX = 8'hdd;
  localparam int AM_IN_BIT = 5;
  localparam int AM_OUT_BIT = 6;
  localparam int MST_MUTE_BIT = 8;
  localparam int EXIT_UP_BIT = 4;
  localparam int SIX_BIT = 3;
  localparam int HI_RATE_BIT = 4;
  localparam logic [7:0] AM_EN_RST = 8'h60;
  localparam logic [3:0] AM_THR_RST = 4'h4;
  localparam logic [3:0] AM_PER_RST = 4'h5;
  localparam logic [8:0] VOL_RST = 9'h048;
  localparam logic [8:0] VOL_UNITY = 9'h048;
  localparam logic [8:0] VOL_MUTE = 9'h1fd;
  localparam logic [2:0] SET_MAX = 3'h4;
  localparam logic [7:0] TONE_IDX_RST = 8'h24;
  localparam logic [2:0] STEP_RST = 3'h0;
  localparam logic [7:0] SLEW_RST = 8'h01;
  localparam logic [24:0] STEP_MAX = 25'h0020000;
endpackage

// ---- verif/audio_tone_volume_mute_ctrl_bench.sv ----
// Purpose: self-checking bench for the tone, volume and mute controller
// Assumes: MS_CYCLES 20 and RAMP_CYCLES 4, so 1 ms is 20 cycles
// Notes: volumes used are multiples of 24 codes, so gains are exact powers of two
`timescale 1ns/1ps
module audio_tone_volume_mute_ctrl_bench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic master_mute_pin_i = 1'b0;
  logic seq_mute_i = 1'b0;
  logic out_ready_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o, low_level_o;
  logic in_valid_i, in_ready_o, out_valid_o, out_tone_en_o, out_loud_en_o, ok;
  logic [2:0] in_chan_i, out_chan_o;
  logic [23:0] in_data_i, out_data_o;
  logic [1:0] out_tone_unit_o;
  logic [11:0] low_set_o;
  logic [8:0] loud_vol_o;
  logic [7:0] byp = 8'hff;
  logic [31:0] q[$];
  int fail_count = 0, total_checks = 0, vol[8], mst = 72, n, r;
  bit mute0 = 0, gm = 0, hi = 0, six = 0;
  audio_tone_volume_mute_ctrl #(.MS_CYCLES(20), .RAMP_CYCLES(4)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .master_mute_pin_i(master_mute_pin_i), .seq_mute_i(seq_mute_i),
    .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .in_chan_i(in_chan_i),
    .in_data_i(in_data_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .out_chan_o(out_chan_o), .out_data_o(out_data_o), .out_tone_unit_o(out_tone_unit_o),
    .out_tone_en_o(out_tone_en_o), .out_loud_en_o(out_loud_en_o), .low_set_o(low_set_o),
    .high_set_o(), .low_level_o(low_level_o), .high_level_o(), .loud_vol_o(loud_vol_o));
  upstream_model i_src (.clk_i(clk_i), .ready_i(in_ready_o), .valid_o(in_valid_i),
    .chan_o(in_chan_i), .data_o(in_data_i));
  initial forever #2 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    // One idle edge keeps the strobe from being lowered and raised in one step
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr_i <= a;
    repeat (2) @(posedge clk_i);
    check(reg_rdata_o & m, e);
  endtask
  // Word layout: skip, loudness, tone inline, tone unit, channel, sample
  function automatic logic [31:0] exp_word(input int c, input int d, input bit skip);
    longint v;
    int e;
    bit sel;
    sel = !hi || c < 2 || c == 7;
    e = 6 - (vol[c] + ((six && (c == 4 || c == 5)) ? 72 : mst)) / 24;
    v = e >= 0 ? longint'(d) <<< e : longint'(d) >>> (-e);
    if (gm || (c == 0 && mute0)) v = 0;
    if (v > 8388607) v = 8388607;
    if (v < -8388608) v = -8388608;
    return {skip, sel, sel && !byp[c],
            2'(hi ? (c == 7 ? 3 : 0) : c < 2 || c == 6 ? 0 : c < 4 ? 1 : c < 6 ? 2 : 3),
            3'(c), 24'(v)};
  endfunction
  task automatic send(input int c, input int d, input bit skip);
    i_src.push(3'(c), 24'(d), 8, ok);
    if (ok) q.push_back(exp_word(c, d, skip));
  endtask
  task automatic traffic(input int fixed, input bit skip);
    for (int c = 0; c < 8; c++) send(c, fixed != 0 ? fixed : int'($urandom % 65536) - 32768, skip);
    i_src.idle();
    repeat (10) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (rst_n_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      if (q.size() == 0) check(32'h0, 32'hffffffff);
      else if (q[0][31]) void'(q.pop_front());
      else check({1'b0, out_loud_en_o, out_tone_en_o, out_tone_unit_o, out_chan_o,
                  out_data_o}, q.pop_front());
    end
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end
  initial begin
    r = $urandom(46);
    for (int i = 0; i < 8; i++) vol[i] = 72;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(8'h04, 32'hffffffff, 32'h60);
    rd(8'h89, 32'hffffffff, 32'h1);
    rd(8'h14, 32'hffffffff, 32'h4);
    rd(8'h15, 32'hffffffff, 32'h5);
    rd(8'h30, 32'hffffffff, 32'h0);
    check(low_level_o, 32'h24242424);
    // Automute stays off until its own scenario so random quiet samples cannot mute
    wr(8'h04, 32'h0);
    wr(8'h14, 32'h1f);
    rd(8'h14, 32'hffffffff, 32'h1c);
    wr(8'h14, 32'h4);
    wr(8'hda, 32'h07020304);
    rd(8'hda, 32'hffffffff, 32'h04020304);
    check(32'(low_set_o), {20'h0, 3'h4, 3'h2, 3'h3, 3'h4});
    wr(8'hdb, 32'h24242622);
    repeat (100) @(posedge clk_i);
    check(low_level_o, 32'h24242622);
    traffic(0, 0);
    for (int c = 0; c < 8; c++) wr(8'h89 + 8'(c), 32'h0);
    byp = 8'h00;
    traffic(0, 0);
    wr(8'hd2, 32'h0);
    wr(8'hd9, 32'h0);
    wr(8'hd1, 32'h30);
    vol[1] = 0;
    mst = 0;
    vol[0] = 48;
    repeat (700) @(posedge clk_i);
    check(32'(loud_vol_o), 32'h0);
    traffic(0, 0);
    // Volume written while muted must be the level reached after unmute
    wr(8'h03, 32'h1);
    wr(8'hd1, 32'h60);
    mute0 = 1;
    vol[0] = 96;
    repeat (700) @(posedge clk_i);
    traffic(0, 0);
    wr(8'h03, 32'h0);
    mute0 = 0;
    for (int s = 1; s < 4; s++) begin
      gm = s < 3;
      master_mute_pin_i <= (s == 1);
      seq_mute_i <= (s == 2);
      repeat (700) @(posedge clk_i);
      traffic(0, 0);
    end
    // Six-channel mode with the next smaller ramp step
    wr(8'h0e, 32'h9);
    six = 1;
    repeat (200) @(posedge clk_i);
    traffic(0, 0);
    wr(8'h0e, 32'h10);
    six = 0;
    hi = 1;
    repeat (100) @(posedge clk_i);
    traffic(0, 0);
    wr(8'h0e, 32'h0);
    hi = 0;
    // Fill the two-entry buffer with the receiver stalled, then drain it
    out_ready_i <= 1'b0;
    n = 0;
    ok = 1'b1;
    for (int i = 1; i < 5 && ok; i++) begin
      send(2, i * 64, 0);
      n += ok;
    end
    i_src.idle();
    check(32'(n), 32'h2);
    out_ready_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    wr(8'h04, 32'h60);
    wr(8'h15, 32'h0);
    for (int i = 0; i < 6; i++) traffic(3, 1);
    rd(8'h02, 32'h104, 32'h104);
    send(2, 32'h7f0, 0);
    i_src.idle();
    repeat (10) @(posedge clk_i);
    rd(8'h02, 32'h4, 32'h0);
    check(32'(q.size()), 32'h0);
    wrap_up();
  end
endmodule

// ---- verif/upstream_model.sv ----
// Purpose: upstream sample source that feeds the controller's input handshake
// Assumes: requests change only just after a rising edge of clk_i
// Notes: a released sample bus shows the inverse of its last value, never a stale copy
`timescale 1ns/1ps
module upstream_model (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [2:0] chan_o,
  output logic [23:0] data_o
);
  initial begin
    valid_o = 1'b0;
    chan_o = 3'h0;
    data_o = 24'h0;
  end
  // Leaves valid up so back to back samples need no idle edge
  task automatic push(input logic [2:0] c, input logic [23:0] d, input int lim,
                      output logic ok);
    ok = 1'b0;
    valid_o <= 1'b1;
    chan_o <= c;
    data_o <= d;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge clk_i);
      ok = (ready_i === 1'b1);
    end
  endtask
  task automatic idle();
    valid_o <= 1'b0;
    chan_o <= ~chan_o;
    data_o <= ~data_o;
  endtask
endmodule
